// ===== hw/ppsc_params.svh
`ifndef PPSC_PARAMS_SVH
`define PPSC_PARAMS_SVH
`define PPSC_ADDR_W 2
`define PPSC_OFF_CFG 2'h0
`define PPSC_OFF_STAT 2'h1
`define PPSC_CCA_LO 4
`define PPSC_CCA_HI 5
`define PPSC_RXN_LO 2
`define PPSC_RXN_HI 3
`define PPSC_TXN_LO 0
`define PPSC_TXN_HI 1
`define PPSC_CFG_RESET 8'h30
`define PPSC_CFG_MASK 8'h3F
`endif

// ===== hw/ppsc_pkg.sv
`default_nettype none
package ppsc_pkg;
   typedef enum logic [1:0] {
      CCA_ALWAYS = 2'h0,
      CCA_RSSI = 2'h1,
      CCA_NOT_RX = 2'h2,
      CCA_RSSI_NOT_RX = 2'h3
   } ppsc_cca_t;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_RX = 3'b001,
      ST_TX = 3'b010,
      ST_SYNTH = 3'b011
   } ppsc_state_t;
   typedef struct packed {
      logic rssi_below;
      logic pkt_receiving;
      logic rx_done;
      logic tx_done;
      logic go_rx;
      logic go_tx;
      logic go_idle;
   } ppsc_radio_in_t;
   typedef struct packed {
      ppsc_state_t state;
      logic clear_channel;
      logic preamble_restart;
      logic cca_conflict;
   } ppsc_radio_out_t;
endpackage
`default_nettype wire

// ===== hw/ppsc_ctrl.sv
// What this block does
// R1 - clear-channel select bits 5:4, reset 11
// R2 - 00 always clear; 01 clear when rssi low
// R3 - 10 clear unless receiving; 11 both conditions
// R4 - rx-done next state bits 3:2, reset 00
// R5 - rx done: idle, synth, tx, stay rx
// R6 - tx-done next state bits 1:0, reset 00
// R7 - tx done: idle, synth, tx+preamble, rx
// R8 - host avoids rx-done tx/synth with cca
// R9 - transition same cycle, current field values
//
// Decided for this implementation: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ns
`include "ppsc_params.svh"
`default_nettype none
module ppsc_ctrl (
   input wire logic mclk,
   input wire logic reset,
   input wire logic [`PPSC_ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire ppsc_pkg::ppsc_radio_in_t radio_in,
   output var ppsc_pkg::ppsc_radio_out_t radio_out
);
   import ppsc_pkg::*;

   logic [7:0] cfg_q;
   logic [31:0] rdata_q;
   logic ack_q;
   ppsc_state_t state_q;
   ppsc_state_t state_d;
   logic cca_q;
   logic cca_d;
   logic pre_q;
   logic conflict_q;
   logic acc;

   function automatic logic cca_eval(input logic [1:0] sel, input logic rssi_lo,
                                     input logic rx_busy);
      unique case (ppsc_cca_t'(sel))
         CCA_ALWAYS: cca_eval = 1'b1;
         CCA_RSSI: cca_eval = rssi_lo;
         CCA_NOT_RX: cca_eval = !rx_busy;
         CCA_RSSI_NOT_RX: cca_eval = rssi_lo && !rx_busy;
      endcase
   endfunction

   wire [1:0] cca_sel = cfg_q[`PPSC_CCA_HI:`PPSC_CCA_LO];
   wire [1:0] rxn = cfg_q[`PPSC_RXN_HI:`PPSC_RXN_LO];
   wire [1:0] txn = cfg_q[`PPSC_TXN_HI:`PPSC_TXN_LO];

   // one wait cycle per access: waitrequest drops the cycle after the request
   assign acc = (avs_read || avs_write) && !ack_q;

   always_ff @(posedge mclk) begin
      if (reset) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= acc;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         avs_waitrequest <= 1'b1;
      end else begin
         avs_waitrequest <= !acc;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         cfg_q <= `PPSC_CFG_RESET; // see R1 see R4 see R6
      end else if (acc && avs_write && avs_address == `PPSC_OFF_CFG && avs_byteenable[0]) begin
         cfg_q <= avs_writedata[7:0] & `PPSC_CFG_MASK;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         rdata_q <= 32'h0;
      end else if (acc && avs_read) begin
         unique case (avs_address)
            `PPSC_OFF_CFG: rdata_q <= {24'h0, cfg_q};
            `PPSC_OFF_STAT: rdata_q <= {27'h0, conflict_q, cca_q, 3'(state_q)};
            default: rdata_q <= 32'h0;
         endcase
      end
   end
   assign avs_readdata = rdata_q;

   assign cca_d = cca_eval(cca_sel, radio_in.rssi_below, radio_in.pkt_receiving); // see R2 see R3

   always_ff @(posedge mclk) begin
      if (reset) begin
         cca_q <= 1'b1;
      end else begin
         cca_q <= cca_d; // see R1
      end
   end

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ST_IDLE: begin
            if (radio_in.go_rx) begin
               state_d = ST_RX;
            end else if (radio_in.go_tx) begin
               state_d = ST_TX;
            end
         end
         ST_RX: begin
            if (radio_in.go_idle) begin
               state_d = ST_IDLE;
            end else if (radio_in.rx_done) begin
               unique case (rxn) // see R5 see R9
                  2'h0: state_d = ST_IDLE;
                  2'h1: state_d = ST_SYNTH;
                  2'h2: state_d = ST_TX;
                  2'h3: state_d = ST_RX;
               endcase
            end
         end
         ST_TX: begin
            if (radio_in.go_idle) begin
               state_d = ST_IDLE;
            end else if (radio_in.tx_done) begin
               unique case (txn) // see R7 see R9
                  2'h0: state_d = ST_IDLE;
                  2'h1: state_d = ST_SYNTH;
                  2'h2: state_d = ST_TX;
                  2'h3: state_d = ST_RX;
               endcase
            end
         end
         ST_SYNTH: begin
            if (radio_in.go_idle) begin
               state_d = ST_IDLE;
            end else if (radio_in.go_tx) begin
               state_d = ST_TX;
            end else if (radio_in.go_rx) begin
               state_d = ST_RX;
            end
         end
         default: state_d = ST_IDLE;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         state_q <= ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         pre_q <= 1'b0;
      end else begin
         pre_q <= state_q == ST_TX && !radio_in.go_idle && radio_in.tx_done
                  && txn == 2'h2; // see R7
      end
   end

   // unsupported combination is only flagged; the device does not block it
   always_ff @(posedge mclk) begin
      if (reset) begin
         conflict_q <= 1'b0;
      end else begin
         conflict_q <= cca_sel != 2'h0 && (rxn == 2'h1 || rxn == 2'h2); // see R8
      end
   end

   assign radio_out.state = state_q;
   assign radio_out.clear_channel = cca_q;
   assign radio_out.preamble_restart = pre_q;
   assign radio_out.cca_conflict = conflict_q;

   property p_rx_done;
      @(posedge mclk) disable iff (reset)
      (state_q == ST_RX && radio_in.rx_done && !radio_in.go_idle && rxn == 2'h2)
         |=> state_q == ST_TX;
   endproperty
   a_rx_done: assert property (p_rx_done) else $error("rx done next state wrong"); // see R5

   property p_rx_idle;
      @(posedge mclk) disable iff (reset)
      (state_q == ST_RX && radio_in.rx_done && rxn == 2'h0) |=> state_q == ST_IDLE;
   endproperty
   a_rx_idle: assert property (p_rx_idle) else $error("rx done idle wrong"); // see R9

   property p_tx_rx;
      @(posedge mclk) disable iff (reset)
      (state_q == ST_TX && radio_in.tx_done && !radio_in.go_idle && txn == 2'h3)
         |=> state_q == ST_RX;
   endproperty
   a_tx_rx: assert property (p_tx_rx) else $error("tx done to rx wrong"); // see R7

   property p_tx_pre;
      @(posedge mclk) disable iff (reset)
      (state_q == ST_TX && radio_in.tx_done && !radio_in.go_idle && txn == 2'h2)
         |=> state_q == ST_TX && pre_q;
   endproperty
   a_tx_pre: assert property (p_tx_pre) else $error("preamble restart missing"); // see R7

   property p_cca_always;
      @(posedge mclk) disable iff (reset)
      cca_sel == 2'h0 |=> cca_q;
   endproperty
   a_cca_always: assert property (p_cca_always) else $error("cca not clear"); // see R2

   property p_cca_rx;
      @(posedge mclk) disable iff (reset)
      (cca_sel[1] && radio_in.pkt_receiving) |=> !cca_q;
   endproperty
   a_cca_rx: assert property (p_cca_rx) else $error("cca clear while receiving"); // see R3

   property p_cca_rssi;
      @(posedge mclk) disable iff (reset)
      (cca_sel[0] && !radio_in.rssi_below) |=> !cca_q;
   endproperty
   a_cca_rssi: assert property (p_cca_rssi) else $error("cca clear on high rssi"); // see R2

   property p_reset_cfg;
      @(posedge mclk) $fell(reset) |-> cfg_q == `PPSC_CFG_RESET;
   endproperty
   a_reset_cfg: assert property (p_reset_cfg) else $error("config reset value wrong"); // see R1

   property p_bus_ack;
      @(posedge mclk) disable iff (reset)
      (avs_read || avs_write) && avs_waitrequest |-> ##[1:2] !avs_waitrequest;
   endproperty
   a_bus_ack: assert property (p_bus_ack) else $error("bus not answered"); // see R4

   property p_rx_synth;
      @(posedge mclk) disable iff (reset)
      (state_q == ST_RX && radio_in.rx_done && !radio_in.go_idle && rxn == 2'h1)
         |=> state_q == ST_SYNTH;
   endproperty
   a_rx_synth: assert property (p_rx_synth) else $error("rx done to synth wrong"); // see R5

   property p_rx_stay;
      @(posedge mclk) disable iff (reset)
      (state_q == ST_RX && radio_in.rx_done && !radio_in.go_idle && rxn == 2'h3)
         |=> state_q == ST_RX;
   endproperty
   a_rx_stay: assert property (p_rx_stay) else $error("rx done did not stay"); // see R5

   property p_tx_idle;
      @(posedge mclk) disable iff (reset)
      (state_q == ST_TX && radio_in.tx_done && txn == 2'h0) |=> state_q == ST_IDLE;
   endproperty
   a_tx_idle: assert property (p_tx_idle) else $error("tx done to idle wrong"); // see R7

   property p_tx_synth;
      @(posedge mclk) disable iff (reset)
      (state_q == ST_TX && radio_in.tx_done && !radio_in.go_idle && txn == 2'h1) |=> state_q == ST_SYNTH;
   endproperty
   a_tx_synth: assert property (p_tx_synth) else $error("tx done to synth wrong"); // see R7

   // the restart pulse must never appear without a finished transmission in stay mode
   property p_pre_only;
      @(posedge mclk) disable iff (reset)
      !(state_q == ST_TX && radio_in.tx_done && !radio_in.go_idle && txn == 2'h2)
         |=> !pre_q;
   endproperty
   a_pre_only: assert property (p_pre_only) else $error("stray preamble restart"); // see R7

   property p_cca_both;
      @(posedge mclk) disable iff (reset)
      (cca_sel == 2'h3 && radio_in.rssi_below && !radio_in.pkt_receiving) |=> cca_q;
   endproperty
   a_cca_both: assert property (p_cca_both) else $error("cca not clear when quiet"); // see R3

   property p_cca_idle_rx;
      @(posedge mclk) disable iff (reset)
      (cca_sel == 2'h2 && !radio_in.pkt_receiving) |=> cca_q;
   endproperty
   a_cca_idle_rx: assert property (p_cca_idle_rx) else $error("cca not clear off rx"); // see R3

   property p_cca_low;
      @(posedge mclk) disable iff (reset)
      (cca_sel == 2'h1 && radio_in.rssi_below) |=> cca_q;
   endproperty
   a_cca_low: assert property (p_cca_low) else $error("cca not clear on low rssi"); // see R2

   property p_cfg_write;
      @(posedge mclk) disable iff (reset)
      (acc && avs_write && avs_address == `PPSC_OFF_CFG && avs_byteenable[0])
         |=> cfg_q == (8'($past(avs_writedata)) & `PPSC_CFG_MASK);
   endproperty
   a_cfg_write: assert property (p_cfg_write) else $error("config write lost"); // see R4

   property p_wait_one;
      @(posedge mclk) disable iff (reset)
      !avs_waitrequest |=> avs_waitrequest;
   endproperty
   a_wait_one: assert property (p_wait_one) else $error("waitrequest low too long"); // see R1

   property p_no_conflict;
      @(posedge mclk) disable iff (reset)
      (cca_sel == 2'h0 || rxn == 2'h0 || rxn == 2'h3) |=> !conflict_q;
   endproperty
   a_no_conflict: assert property (p_no_conflict) else $error("conflict flagged wrongly"); // see R8

   c_rx_tx: cover property (@(posedge mclk) state_q == ST_RX ##1 state_q == ST_TX);
   c_tx_synth: cover property (@(posedge mclk) state_q == ST_TX ##1 state_q == ST_SYNTH);
   c_pre: cover property (@(posedge mclk) pre_q);
   c_cca_off: cover property (@(posedge mclk) cca_sel == 2'h3 && !cca_q);
   c_tx_rx: cover property (@(posedge mclk) state_q == ST_TX ##1 state_q == ST_RX);
endmodule
`default_nettype wire

// ===== dv/tb_top.sv
`timescale 1ns/1ns
`include "ppsc_params.svh"
`default_nettype none
module tb_top;
   import ppsc_pkg::*;
   logic mclk, reset, avs_read, avs_write, avs_waitrequest;
   logic [`PPSC_ADDR_W-1:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, rd, seed;
   logic [3:0] avs_byteenable;
   logic [1:0] m;
   logic [1:0] c;
   ppsc_radio_in_t rin;
   ppsc_radio_out_t rout;
   ppsc_state_t exp_st[4];
   int num_errors = 0;
   int n_checks = 0;
   ppsc_ctrl dut_u (
      .mclk(mclk),
      .reset(reset),
      .avs_address(avs_address),
      .avs_read(avs_read),
      .avs_write(avs_write),
      .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest),
      .radio_in(rin),
      .radio_out(rout)
   );
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
   endfunction
   function automatic logic cca_exp(input logic [1:0] md, input logic r, input logic p);
      case (md)
         2'h0: return 1'b1;
         2'h1: return r;
         2'h2: return !p;
         default: return r && !p;
      endcase
   endfunction
   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      n_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("FAIL %0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask
   // request held until waitrequest is sampled low; one idle edge after release
   task automatic bus(input logic wr, input logic [1:0] a, input logic [31:0] d,
                      input logic [3:0] be, output logic [31:0] q);
      int i;
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= be;
      avs_read <= !wr;
      avs_write <= wr;
      for (i = 0; i < 20; i++) begin
         @(posedge mclk);
         if (avs_waitrequest === 1'b0) break;
      end
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (i == 20) begin
         num_errors++;
         $display("FAIL %0t bus timeout", $time);
         finish_test();
      end
      @(posedge mclk);
   endtask
   task automatic step(input logic [6:0] v);
      rin <= v;
      @(posedge mclk);
   endtask
   initial begin
      reset = 1'b1;
      avs_address = '0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = '0;
      avs_byteenable = 4'hF;
      rin = '0;
      seed = 32'h7233A220;
      exp_st = '{ST_IDLE, ST_SYNTH, ST_TX, ST_RX};
      repeat (2) @(posedge mclk);
      reset <= 1'b0;
      @(posedge mclk);
      bus(1'b0, 2'h0, 32'h0, 4'hF, rd);
      chk(rd, 32'h30, "cfg reset");
      bus(1'b0, 2'h1, 32'h0, 4'hF, rd);
      // reset mode 11 with rssi high reads back as not clear
      chk(rd, {28'h0, cca_exp(2'h3, 1'b0, 1'b0), 3'h0}, "status reset");
      bus(1'b1, 2'h0, 32'h0, 4'h0, rd);
      bus(1'b1, 2'h3, 32'h0, 4'hF, rd);
      bus(1'b0, 2'h0, 32'h0, 4'hF, rd);
      chk(rd, 32'h30, "cfg after ignored writes");
      bus(1'b0, 2'h2, 32'h0, 4'hF, rd);
      chk(rd, 32'h0, "unmapped read");
      bus(1'b1, 2'h0, 32'hFF, 4'hF, rd);
      bus(1'b0, 2'h0, 32'h0, 4'hF, rd);
      chk(rd, 32'h3F, "cfg all ones");
      $display("register test done");
      for (int k = 0; k < 4; k++) begin
         m = k[1:0];
         bus(1'b1, 2'h0, {26'h0, m, 4'h0}, 4'hF, rd);
         for (int j = 0; j < 8; j++) begin
            seed = lfsr(seed);
            step({seed[1:0], 5'h0});
            @(posedge mclk);
            chk(32'(rout.clear_channel), 32'(cca_exp(m, seed[1], seed[0])), "cca");
         end
      end
      $display("clear channel test done");
      for (int k = 0; k < 8; k++) begin
         c = k[1:0];
         // cca off while rx field picks tx or synth: that pairing is allowed, so no conflict is flagged
         bus(1'b1, 2'h0, k < 4 ? {28'h0, c, 2'h0} : {30'h0, c}, 4'hF, rd);
         step(k < 4 ? 7'h04 : 7'h02);
         step(k < 4 ? 7'h10 : 7'h08);
         step(7'h00);
         chk(32'(rout.state), 32'(exp_st[c]), "next state");
         chk(32'(rout.preamble_restart), 32'(k == 6), "preamble");
         chk(32'(rout.cca_conflict), 32'h0, "conflict flag");
         step(7'h01);
         step(7'h00);
      end
      $display("completion test done");
      finish_test();
   end
endmodule
`default_nettype wire
